// file: core/cdmv_core.sv
// Digital mix, volume, format conversion and rate generation for a four-resource codec.
// Assumes AXI4-Lite register access and sample strobes synchronous to sys_clk_i.
`timescale 1ns/100ps
module cdmv_core #(
    parameter int DPLL_SHIFT = cdmv_pkg::DPLL_SHIFT_DEF
) (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // AXI4-Lite slave
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Rate reference inputs
    input wire logic [2:0] sync_i,
    // Playback sample input, left in [31:16]
    input wire logic [1:0][31:0] pb_data_i,
    input wire logic [1:0] pb_valid_i,
    output logic [1:0] pb_ready_o,
    // Capture from converters
    input wire logic [1:0][15:0] cap_data_i,
    input wire logic [1:0] cap_ovr_i,
    // Capture to serial side
    output logic [1:0][15:0] cap_data_o,
    output logic [1:0] cap_valid_o,
    // Playback to converters
    output logic [3:0][15:0] play_data_o,
    output logic [1:0] play_valid_o,
    // Resource sample ticks
    output logic [3:0] rate_tick_o
);
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [7:0] waddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [31:0] ctrl;
        logic [1:0][31:0] vol;
        logic [31:0] mix;
        logic [3:0][31:0] rate;
        logic [1:0] ovr;
        logic [1:0] unr;
        logic [3:0][30:0] nco;
        logic [3:0] nco_tick;
        logic [3:0] tick;
        logic [2:0] sync_q;
        logic [2:0] seen;
        logic [2:0] lock;
        logic [2:0] hold;
        logic [2:0][19:0] dcnt;
        logic [2:0][19:0] dper;
        logic [2:0][19:0] dph;
        logic [2:0] dtick;
        logic [1:0][3:0][31:0] qmem;
        logic [1:0][1:0] qwp;
        logic [1:0][1:0] qrp;
        logic [1:0][2:0] qcnt;
        logic [1:0] pb_ready;
        logic [1:0][15:0] cap_lin;
        logic [1:0][15:0] cap_out;
        logic [1:0] cap_valid;
        logic [3:0][6:0] cur_att;
        logic [3:0][8:0] zc_tmr;
        logic [3:0] prev_sgn;
        logic [3:0][15:0] play_out;
        logic [1:0] play_valid;
    } cdmv_state_type;

    cdmv_state_type s;
    cdmv_state_type n;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] strb, input logic [31:0] mask);
        logic [31:0] m;
        m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & mask;
        merge = (old & ~m) | (d & m);
    endfunction

    function automatic logic [15:0] sat16(input logic [33:0] v);
        if (!v[33] && |v[32:15]) begin
            sat16 = 16'h7fff;
        end else if (v[33] && !(&v[32:15])) begin
            sat16 = 16'h8000;
        end else begin
            sat16 = v[15:0];
        end
    endfunction

    // Gain = mantissa(code mod 4) >> (base + code/4), one 1.5 dB per code
    function automatic logic [15:0] scale(input logic [15:0] x, input logic [5:0] code,
                                          input logic [4:0] base);
        logic signed [33:0] p;
        logic [4:0] sh;
        p = 34'($signed(x)) * 34'($signed({1'b0, cdmv_pkg::GAIN_MANT[code[1:0]]}));
        sh = base + {1'b0, code[5:2]};
        scale = sat16(34'(p >>> sh));
    endfunction

    function automatic logic [15:0] to_lin(input cdmv_pkg::cdmv_fmt_type fmt, input logic [15:0] raw);
        logic [7:0] v;
        logic [15:0] t;
        v = 8'h00;
        t = 16'h0000;
        case (fmt)
            cdmv_pkg::FMT_U8: begin
                to_lin = {raw[15:8] ^ 8'h80, 8'h00};
            end
            cdmv_pkg::FMT_MULAW: begin
                v = ~raw[15:8];
                t = ({9'h000, v[3:0], 3'h0} + 16'h0084) << v[6:4];
                t = t - 16'h0084;
                to_lin = v[7] ? 16'h0000 - t : t;
            end
            cdmv_pkg::FMT_ALAW: begin
                v = raw[15:8] ^ 8'h55;
                t = {8'h00, v[3:0], 4'h0};
                if (v[6:4] == 3'h0) begin
                    t = t + 16'h0008;
                end else begin
                    t = (t + 16'h0108) << (v[6:4] - 3'h1);
                end
                to_lin = v[7] ? t : 16'h0000 - t;
            end
            default: begin
                to_lin = raw;
            end
        endcase
    endfunction

    function automatic logic [15:0] from_lin(input cdmv_pkg::cdmv_fmt_type fmt, input logic [15:0] x);
        logic [15:0] mag;
        logic [2:0] e;
        logic [3:0] m;
        mag = x[15] ? 16'h0000 - x : x;
        e = 3'h0;
        m = 4'h0;
        case (fmt)
            cdmv_pkg::FMT_U8: begin
                from_lin = {x[15:8] ^ 8'h80, 8'h00};
            end
            cdmv_pkg::FMT_MULAW: begin
                if (mag > cdmv_pkg::MU_CLIP) begin
                    mag = cdmv_pkg::MU_CLIP;
                end
                mag = mag + 16'h0084;
                for (int i = 1; i < 8; i++) begin
                    if (mag[i + 7]) begin
                        e = 3'(i);
                    end
                end
                m = 4'(mag >> ({1'b0, e} + 4'h3));
                from_lin = {~{x[15], e, m}, 8'h00};
            end
            cdmv_pkg::FMT_ALAW: begin
                if (mag > 16'h7fff) begin
                    mag = 16'h7fff;
                end
                for (int i = 1; i < 8; i++) begin
                    if (mag[i + 7]) begin
                        e = 3'(i);
                    end
                end
                m = (e == 3'h0) ? mag[7:4] : 4'(mag >> ({1'b0, e} + 4'h3));
                from_lin = {{~x[15], e, m} ^ 8'h55, 8'h00};
            end
            default: begin
                from_lin = x;
            end
        endcase
    endfunction

    always_comb begin
        logic [18:0] step;
        logic [31:0] sum;
        logic [1:0] src;
        logic [19:0] meas;
        logic [20:0] diff;
        logic [31:0] word;
        logic [15:0] lin;
        logic [15:0] mixv;
        logic [16:0] acc;
        logic [15:0] smp;
        logic [6:0] tgt;
        logic [31:0] rv;
        int c;
        step = '0;
        sum = '0;
        src = '0;
        meas = '0;
        diff = '0;
        word = '0;
        lin = '0;
        mixv = '0;
        acc = '0;
        smp = '0;
        tgt = '0;
        rv = '0;
        c = 0;
        n = s;
        n.cap_valid = '0;
        n.play_valid = '0;
        n.dtick = '0;

        // Register writes, address and data in either order
        if (s.awready && s_axi_awvalid_i) begin
            n.awready = 1'b0;
            n.aw_got = 1'b1;
            n.waddr = s_axi_awaddr_i;
        end
        if (s.wready && s_axi_wvalid_i) begin
            n.wready = 1'b0;
            n.w_got = 1'b1;
            n.wdata = s_axi_wdata_i;
            n.wstrb = s_axi_wstrb_i;
        end
        if (s.aw_got && s.w_got) begin
            n.aw_got = 1'b0;
            n.w_got = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = cdmv_pkg::RESP_OKAY;
            if (s.waddr == cdmv_pkg::OFF_CTRL) begin
                n.ctrl = merge(s.ctrl, s.wdata, s.wstrb, cdmv_pkg::CTRL_MASK);
            end else if (s.waddr == cdmv_pkg::OFF_VOL1 || s.waddr == cdmv_pkg::OFF_VOL2) begin
                n.vol[s.waddr[3]] = merge(s.vol[s.waddr[3]], s.wdata, s.wstrb, cdmv_pkg::VOL_MASK);
            end else if (s.waddr == cdmv_pkg::OFF_MIX) begin
                n.mix = merge(s.mix, s.wdata, s.wstrb, cdmv_pkg::VOL_MASK);
            end else if (s.waddr[7:4] == cdmv_pkg::OFF_RATE_HI && s.waddr[1:0] == 2'h0) begin
                rv = merge(s.rate[s.waddr[3:2]], s.wdata, s.wstrb, cdmv_pkg::RATE_MASK);
                if (rv[15:0] < cdmv_pkg::RATE_MIN) begin
                    rv[15:0] = cdmv_pkg::RATE_MIN;
                end else if (rv[15:0] > cdmv_pkg::RATE_MAX) begin
                    rv[15:0] = cdmv_pkg::RATE_MAX;
                end
                n.rate[s.waddr[3:2]] = rv;
            end else if (s.waddr == cdmv_pkg::OFF_STAT) begin
                if (s.wstrb[0]) begin
                    n.ovr = s.ovr & ~s.wdata[1:0];
                    n.unr = s.unr & ~s.wdata[3:2];
                end
            end else begin
                n.bresp = cdmv_pkg::RESP_SLVERR;
            end
        end
        if (s.bvalid && s_axi_bready_i) begin
            n.bvalid = 1'b0;
            n.awready = 1'b1;
            n.wready = 1'b1;
        end

        // Register reads
        if (s.arready && s_axi_arvalid_i) begin
            n.arready = 1'b0;
            n.rvalid = 1'b1;
            n.rresp = cdmv_pkg::RESP_OKAY;
            n.rdata = '0;
            if (s_axi_araddr_i == cdmv_pkg::OFF_CTRL) begin
                n.rdata = s.ctrl;
            end else if (s_axi_araddr_i == cdmv_pkg::OFF_VOL1 || s_axi_araddr_i == cdmv_pkg::OFF_VOL2) begin
                n.rdata = s.vol[s_axi_araddr_i[3]];
            end else if (s_axi_araddr_i == cdmv_pkg::OFF_MIX) begin
                n.rdata = s.mix;
            end else if (s_axi_araddr_i[7:4] == cdmv_pkg::OFF_RATE_HI && s_axi_araddr_i[1:0] == 2'h0) begin
                n.rdata = s.rate[s_axi_araddr_i[3:2]];
            end else if (s_axi_araddr_i == cdmv_pkg::OFF_STAT) begin
                n.rdata = 32'({s.hold, s.lock, s.unr, s.ovr});
            end else begin
                n.rresp = cdmv_pkg::RESP_SLVERR;
            end
        end
        if (s.rvalid && s_axi_rready_i) begin
            n.rvalid = 1'b0;
            n.arready = 1'b1;
        end

        // Rate generators: modulus is 7 * clock so 8/7 is an exact step change
        for (int r = 0; r < 4; r++) begin
            step = {s.rate[r][15:0], 3'h0};
            if (!s.rate[r][cdmv_pkg::RATE_MODEM_BIT]) begin
                step = step - {3'h0, s.rate[r][15:0]};
            end
            sum = {1'b0, s.nco[r]} + {13'h0000, step};
            n.nco_tick[r] = (sum >= cdmv_pkg::NCO_MOD);
            n.nco[r] = n.nco_tick[r] ? 31'(sum - cdmv_pkg::NCO_MOD) : sum[30:0];
            src = s.rate[r][cdmv_pkg::RATE_SRC_LSB +: 2];
            n.tick[r] = (src == 2'h0) ? s.nco_tick[r] : s.dtick[2'(src - 2'h1)];
        end

        // Rate-tracking loops on the reference inputs
        for (int k = 0; k < 3; k++) begin
            n.sync_q[k] = sync_i[k];
            if (sync_i[k] && !s.sync_q[k]) begin
                n.dcnt[k] = '0;
                n.hold[k] = 1'b0;
                n.seen[k] = 1'b1;
                if (s.seen[k]) begin
                    meas = s.dcnt[k] + 20'h00001;
                    n.lock[k] = 1'b1;
                    if (s.lock[k]) begin
                        diff = {1'b0, meas} - {1'b0, s.dper[k]};
                        n.dper[k] = s.dper[k] + 20'($signed(diff) >>> DPLL_SHIFT);
                    end else begin
                        n.dper[k] = meas;
                    end
                end
            end else begin
                if (s.dcnt[k] != 20'hfffff) begin
                    n.dcnt[k] = s.dcnt[k] + 20'h00001;
                end
                if (s.lock[k] && {1'b0, s.dcnt[k]} > {s.dper[k], 1'b0}) begin
                    n.hold[k] = 1'b1;
                end
            end
            // Keeps ticking on the held period when the reference stops
            if (s.lock[k]) begin
                if (s.dph[k] + 20'h00001 >= s.dper[k]) begin
                    n.dph[k] = '0;
                    n.dtick[k] = 1'b1;
                end else begin
                    n.dph[k] = s.dph[k] + 20'h00001;
                end
            end
        end

        // Capture side
        for (int ch = 0; ch < 2; ch++) begin
            if (cap_ovr_i[ch]) begin
                n.ovr[ch] = 1'b1;
            end
            if (s.tick[ch]) begin
                n.cap_lin[ch] = cap_data_i[ch];
                n.cap_out[ch] = from_lin(cdmv_pkg::cdmv_fmt_type'(s.ctrl[2 * ch +: 2]), cap_data_i[ch]);
                n.cap_valid[ch] = 1'b1;
            end
        end

        // Playback pairs
        for (int p = 0; p < 2; p++) begin
            word = s.qmem[p][s.qrp[p]];
            if (s.tick[p + 2]) begin
                if (s.qcnt[p] != 3'h0) begin
                    n.qrp[p] = s.qrp[p] + 2'h1;
                    n.qcnt[p] = s.qcnt[p] - 3'h1;
                end else begin
                    word = '0;
                    if (s.ctrl[cdmv_pkg::CTRL_PB_LSB + p]) begin
                        n.unr[p] = 1'b1;
                    end
                end
                n.play_valid[p] = 1'b1;
                for (int ch = 0; ch < 2; ch++) begin
                    c = 2 * p + ch;
                    lin = to_lin(cdmv_pkg::cdmv_fmt_type'(s.ctrl[2 * (p + 2) +: 2]),
                                 ch == 0 ? word[31:16] : word[15:0]);
                    if (s.qcnt[p] == 3'h0) begin
                        lin = 16'h0000;
                    end
                    tgt = s.mix[ch * cdmv_pkg::ATT_R_LSB +: cdmv_pkg::ATT_W];
                    mixv = '0;
                    if (s.ctrl[cdmv_pkg::CTRL_MIX_LSB + p] && !tgt[cdmv_pkg::ATT_MUTE_BIT]) begin
                        mixv = scale(s.cap_lin[ch], tgt[5:0], cdmv_pkg::MIX_BASE);
                    end
                    acc = {lin[15], lin} + {mixv[15], mixv};
                    smp = (acc[16] != acc[15]) ? (acc[16] ? 16'h8000 : 16'h7fff) : acc[15:0];
                    tgt = s.vol[p][ch * cdmv_pkg::ATT_R_LSB +: cdmv_pkg::ATT_W];
                    if (s.cur_att[c] != tgt) begin
                        if (!s.ctrl[cdmv_pkg::CTRL_ZC_BIT] || smp[15] != s.prev_sgn[c]
                            || s.zc_tmr[c] >= cdmv_pkg::ZC_TIMEOUT_SAMPLES - 9'h001) begin
                            n.cur_att[c] = tgt;
                            n.zc_tmr[c] = '0;
                        end else begin
                            n.zc_tmr[c] = s.zc_tmr[c] + 9'h001;
                        end
                    end else begin
                        n.zc_tmr[c] = '0;
                    end
                    n.prev_sgn[c] = smp[15];
                    n.play_out[c] = n.cur_att[c][cdmv_pkg::ATT_MUTE_BIT] ? 16'h0000
                                  : scale(smp, n.cur_att[c][5:0], cdmv_pkg::PB_BASE);
                end
            end
            if (pb_valid_i[p] && s.pb_ready[p]) begin
                n.qmem[p][s.qwp[p]] = pb_data_i[p];
                n.qwp[p] = s.qwp[p] + 2'h1;
                n.qcnt[p] = n.qcnt[p] + 3'h1;
            end
            n.pb_ready[p] = (n.qcnt[p] < 3'(cdmv_pkg::QDEPTH));
        end
    end

    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            s <= '0;
            s.awready <= 1'b1;
            s.wready <= 1'b1;
            s.arready <= 1'b1;
            s.ctrl <= cdmv_pkg::CTRL_RST;
            s.vol <= {cdmv_pkg::VOL_RST, cdmv_pkg::VOL_RST};
            s.mix <= cdmv_pkg::MIX_RST;
            s.rate <= {4{cdmv_pkg::RATE_RST}};
            s.pb_ready <= 2'h3;
            s.cur_att <= {4{cdmv_pkg::ATT_RST}};
        end else begin
            s <= n;
        end
    end

    assign s_axi_awready_o = s.awready;
    assign s_axi_wready_o = s.wready;
    assign s_axi_bresp_o = s.bresp;
    assign s_axi_bvalid_o = s.bvalid;
    assign s_axi_arready_o = s.arready;
    assign s_axi_rdata_o = s.rdata;
    assign s_axi_rresp_o = s.rresp;
    assign s_axi_rvalid_o = s.rvalid;
    assign pb_ready_o = s.pb_ready;
    assign cap_data_o = s.cap_out;
    assign cap_valid_o = s.cap_valid;
    assign play_data_o = s.play_out;
    assign play_valid_o = s.play_valid;
    assign rate_tick_o = s.tick;
endmodule

// file: shared/cdmv_pkg.sv
// Constants, field layout and format codes for the codec digital mix/volume core.
// Assumes a single 250 MHz system clock and an AXI4-Lite register master.
//
// Functional notes
// - Each playback channel has its own attenuator, +12 to -82.5 dB, 1.5 dB steps, mute.
// - Volume change applies at once or at the channel's next sign change.
// - Pending volume change is forced after 384 sample periods without a sign change.
// - Capture samples may be mixed into playback; outgoing capture data stays unchanged.
// - Capture mix attenuation per side, 64 steps of 1.5 dB down to -94.5 dB.
// - Mix path mute removes all capture contribution from the playback sum.
// - Mix is added ahead of the playback attenuator, so it is scaled twice.
// - Mix plus playback sum saturates at full scale, never wraps.
// - Missing playback sample at sample time is replaced by zero in the sum.
// - Internal processing is 16-bit two's-complement; conversions only at the boundary.
// - Each resource selects 16-bit linear, 8-bit unsigned, mu-law or A-law.
// - Samples of every format are carried most significant bit first.
// - 8-bit samples sit in the upper byte; low byte ignored in, zero out.
// - Companded input expands to full-scale-aligned linear, 14-bit mu, 13-bit A magnitude.
// - Companded capture channels compress linear data to the chosen law before output.
// - Capture overrange events set software-readable status bits.
// - Rate generators give 4 kHz to 54 kHz in 1 Hz steps, changeable while running.
// - A control bit scales the programmed rate by 8/7 for modem rates.
// - Three rate-tracking loops, each on one reference input, assignable to any resource.
// - A loop whose reference stops keeps its last tracked rate, within one percent.
// - Each loop uses a first-order low-pass on the measured period.
// - Each playback pair has a four-entry queue; empty at sample time is underrun if the pair's CTRL_PB_LSB control bit is set.
package cdmv_pkg;
    localparam int unsigned CLK_HZ = 250_000_000;
    localparam logic [31:0] NCO_MOD = 32'h684e_e180;

    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_VOL1 = 8'h04;
    localparam logic [7:0] OFF_VOL2 = 8'h08;
    localparam logic [7:0] OFF_MIX = 8'h0c;
    localparam logic [3:0] OFF_RATE_HI = 4'h1;
    localparam logic [7:0] OFF_STAT = 8'h20;

    localparam int CTRL_FMT_LSB = 0;
    localparam int CTRL_ZC_BIT = 8;
    localparam int CTRL_MIX_LSB = 9;
    localparam int CTRL_PB_LSB = 11;
    localparam logic [31:0] CTRL_MASK = 32'h0000_1fff;
    localparam logic [31:0] CTRL_RST = 32'h0000_0100;

    localparam int ATT_W = 7;
    localparam int ATT_MUTE_BIT = 6;
    localparam int ATT_R_LSB = 8;
    localparam logic [31:0] VOL_MASK = 32'h0000_7f7f;
    localparam logic [31:0] VOL_RST = 32'h0000_0808;
    localparam logic [6:0] ATT_RST = 7'h08;
    localparam logic [31:0] MIX_RST = 32'h0000_4040;

    localparam int RATE_MODEM_BIT = 16;
    localparam int RATE_SRC_LSB = 17;
    localparam logic [31:0] RATE_MASK = 32'h0007_ffff;
    localparam logic [31:0] RATE_RST = 32'h0000_bb80;
    localparam logic [15:0] RATE_MIN = 16'h0fa0;
    localparam logic [15:0] RATE_MAX = 16'hd2f0;

    localparam int ZC_TIMEOUT_MS_X_KHZ = 384;
    localparam logic [8:0] ZC_TIMEOUT_SAMPLES = 9'(ZC_TIMEOUT_MS_X_KHZ);

    localparam int QDEPTH = 4;
    localparam int DPLL_SHIFT_DEF = 4;
    localparam logic [4:0] PB_BASE = 5'h0d;
    localparam logic [4:0] MIX_BASE = 5'h0f;
    localparam logic [16:0] GAIN_MANT [4] = '{17'h08000, 17'h06bb3, 17'h05a9e, 17'h04c3f};
    localparam logic [15:0] MU_CLIP = 16'h7f7b;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {FMT_LIN16, FMT_U8, FMT_MULAW, FMT_ALAW} cdmv_fmt_type;
endpackage

// file: verif/cdmv_checker.sv
// Port checker for the codec mix/volume core.
// Bound into cdmv_core; sees only its ports.
`timescale 1ns/100ps
module cdmv_checker (
    // Clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_i,
    // AXI handshakes
    input wire logic s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o,
    input wire logic s_axi_bvalid_o, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i,
    // Stream side
    input wire logic [1:0] pb_valid_i, pb_ready_o, play_valid_o, cap_valid_o,
    input wire logic [3:0] rate_tick_o
);
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);
    logic [2:0] fill;
    sequence wr_taken;
        s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
    endsequence
    sequence rd_taken;
        s_axi_arvalid_i && s_axi_arready_o;
    endsequence
    // Primary queue fill
    always_ff @(posedge sys_clk_i or posedge rst_i) begin
        if (rst_i) begin
            fill <= 3'h0;
        end else begin
            fill <= fill + 3'(pb_valid_i[0] && pb_ready_o[0]) - 3'(rate_tick_o[2] && fill != 3'h0);
        end
    end
    AST_WR_ANSWER: assert property (wr_taken |-> ##2 s_axi_bvalid_o) else $error("write answer late");
    AST_RD_ANSWER: assert property (rd_taken |=> s_axi_rvalid_o) else $error("read answer late");
    AST_AW_BLOCK: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
        else $error("write taken during answer");
    AST_RD_DONE: assert property (s_axi_rvalid_o && s_axi_rready_i |=> !s_axi_rvalid_o && s_axi_arready_o)
        else $error("read not released");
    AST_TICK_PULSE: assert property (rate_tick_o[2] |=> !rate_tick_o[2]) else $error("tick too long");
    AST_PLAY_ON_TICK: assert property (rate_tick_o[2] |=> play_valid_o[0]) else $error("no sample");
    AST_PLAY_CAUSE: assert property (play_valid_o[0] |-> $past(rate_tick_o[2])) else $error("stray sample");
    AST_CAP_ON_TICK: assert property (rate_tick_o[0] |=> cap_valid_o[0]) else $error("no capture");
    AST_QUEUE_READY: assert property (pb_ready_o[0] == (fill != 3'h4)) else $error("ready vs fill");
endmodule
bind cdmv_core cdmv_checker i_cdmv_checker (.*);

// file: verif/cdmv_pb_source.sv
// Serial-side sample source feeding the primary playback stream.
// Words are offered after a clock edge and held until taken.
`timescale 1ns/100ps
module cdmv_pb_source (
    // Clock
    input wire logic sys_clk_i,
    // Stream to the block
    input wire logic ready_i,
    output logic [31:0] data_o,
    output logic valid_o
);
    initial begin
        data_o = 32'h0;
        valid_o = 1'b0;
    end
    // Left field MSB at bit 31, right at bit 15; released data scrambled
    task automatic push(input logic [31:0] w);
        @(posedge sys_clk_i);
        data_o <= w;
        valid_o <= 1'b1;
        do @(posedge sys_clk_i); while (ready_i !== 1'b1);
        valid_o <= 1'b0;
        data_o <= ~w;
    endtask
endmodule

// file: verif/tb_top.sv
// Self-checking bench for the codec mix/volume core.
// Registers over AXI4-Lite, playback through the source model.
`timescale 1ns/100ps
module tb_top;
    logic sys_clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, src_valid;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [7:0] s_axi_awaddr_i, s_axi_araddr_i;
    logic [31:0] s_axi_wdata_i, s_axi_rdata_o, src_data;
    logic [1:0] cap_ovr_i, s_axi_bresp_o, s_axi_rresp_o, cap_valid_o, play_valid_o, pb_ready_o;
    logic [1:0][15:0] cap_data_i, cap_data_o;
    logic [3:0][15:0] play_data_o;
    logic [3:0] rate_tick_o;
    wire [1:0][31:0] pb_data_i = {32'h0, src_data};
    wire [1:0] pb_valid_i = {1'b0, src_valid};
    int fail_count, n_compared;
    cdmv_core i_cdmv_core (.*, .s_axi_wstrb_i(4'hf), .s_axi_bready_i(1'b1), .s_axi_rready_i(1'b1), .sync_i(3'h0));
    cdmv_pb_source i_cdmv_pb_source (.sys_clk_i(sys_clk_i), .ready_i(pb_ready_o[0]), .data_o(src_data),
        .valid_o(src_valid));
    initial begin
        sys_clk_i = 1'b0;
        forever #2 sys_clk_i = ~sys_clk_i;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        do @(posedge sys_clk_i); while (!(s_axi_awready_o && s_axi_wready_o));
        s_axi_awvalid_i <= 1'b0;
        s_axi_wvalid_i <= 1'b0;
        do @(posedge sys_clk_i); while (s_axi_bvalid_o !== 1'b1);
        check({30'h0, s_axi_bresp_o}, 32'h0);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m, input logic [1:0] r);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        do @(posedge sys_clk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge sys_clk_i); while (s_axi_rvalid_o !== 1'b1);
        check(s_axi_rdata_o & m, exp);
        check({30'h0, s_axi_rresp_o}, {30'h0, r});
    endtask
    task automatic play(input logic [31:0] w, input logic [31:0] exp);
        if (w !== 32'h0) begin
            i_cdmv_pb_source.push(w);
        end
        do @(posedge sys_clk_i); while (play_valid_o[0] !== 1'b1);
        check({play_data_o[0], play_data_o[1]}, exp);
    endtask
    task automatic test_regs;
        rd(8'h04, 32'h0000_0808, '1, 2'h0);
        rd(8'h24, 32'h0, '1, 2'h2);
        wr(8'h18, 32'h0000_03e8);
        rd(8'h18, 32'h0000_0fa0, '1, 2'h0);
        wr(8'h18, 32'h0000_d2f0);
        wr(8'h10, 32'h0000_d2f0);
        $display("test_regs done");
    endtask
    task automatic test_play;
        logic [31:0] w [3] = '{32'hff12_80ab, 32'h8000_0000, 32'haa00_2a00};
        logic [31:0] e [3] = '{32'h7f00_0000, 32'h7d7c_8284, 32'h7e00_8200};
        wr(8'h00, 32'h0000_0800);
        play(32'h0, 32'h0);
        play(32'h1234_edcc, 32'h1234_edcc);
        wr(8'h04, 32'h0000_4000);
        play(32'h0100_7000, 32'h0400_0000);
        rd(8'h20, 32'h4, 32'h4, 2'h0);
        wr(8'h04, 32'h0000_0808);
        for (int f = 1; f < 4; f++) begin
            wr(8'h00, 32'h0000_0800 | 32'(f << 4));
            play(w[f-1], e[f-1]);
        end
        play(32'h0, 32'h0);
        $display("test_play done");
    endtask
    task automatic test_mix;
        wr(8'h00, 32'h0000_0a00);
        wr(8'h0c, 32'h0);
        do @(posedge sys_clk_i); while (cap_valid_o[0] !== 1'b1);
        check({16'h0, cap_data_o[0]}, 32'h7000);
        play(32'h0, 32'h7000_8000);
        play(32'h7000_9000, 32'h7fff_8000);
        wr(8'h0c, 32'h0000_0404);
        wr(8'h04, 32'h0000_0c0c);
        play(32'h0800_0000, 32'h2000_e000);
        wr(8'h0c, 32'h0000_4040);
        wr(8'h04, 32'h0000_0808);
        play(32'h1000_f000, 32'h1000_f000);
        wr(8'h00, 32'h0000_0b00);
        wr(8'h04, 32'h0000_0c0c);
        play(32'h2000_1000, 32'h2000_0800);
        cap_ovr_i <= 2'h3;
        @(posedge sys_clk_i);
        cap_ovr_i <= 2'h0;
        rd(8'h20, 32'h3, 32'h3, 2'h0);
        wr(8'h20, 32'h3);
        rd(8'h20, 32'h0, 32'h3, 2'h0);
        wr(8'h00, 32'h0000_0002);
        do @(posedge sys_clk_i); while (cap_valid_o[0] !== 1'b1);
        check({16'h0, cap_data_o[0]}, 32'h8300);
        $display("test_mix done");
    endtask
    task automatic final_report;
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        rst_i = 1'b1;
        {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_arvalid_i, cap_ovr_i} = 5'h0;
        {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i} = 48'h0;
        cap_data_i = {16'h8000, 16'h7000};
        repeat (3) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        @(posedge sys_clk_i);
        test_regs;
        test_play;
        test_mix;
        final_report;
    end
    // Watchdog, about 19 sample periods
    initial begin
        repeat (90000) @(posedge sys_clk_i);
        fail_count++;
        final_report;
    end
endmodule
